// ===== shared/pcrc_pkg.sv
// Constants for the programmable CRC generator.
// Assumes one 50 MHz clock and a synchronous active-low reset.
package pcrc_pkg;
  localparam int unsigned PCRC_W        = 16;
  localparam int unsigned PCRC_LEN_W    = 4;
  localparam int unsigned PCRC_FIFO_D   = 8;
  localparam int unsigned PCRC_PTR_W    = 3;
  localparam int unsigned PCRC_CNT_W    = 4;
  localparam int unsigned PCRC_BIT_W    = 5;
  localparam logic [15:0] PCRC_RST_VAL  = 16'h0000;
  localparam logic [3:0]  PCRC_CNT_FULL = 4'h8;
  localparam logic [4:0]  PCRC_BITS_WORD = 5'h10;
  localparam logic [4:0]  PCRC_BIT_ONE  = 5'h01;
  typedef enum logic [1:0] {PCRC_IDLE, PCRC_LOAD, PCRC_SHIFT} pcrc_state_t;
endpackage

// ===== rtl/pcrc_fifo_mem.sv
// Small word memory for the CRC data FIFO.
// Assumes one clock; read data are registered.
`timescale 1ns/1ns
`default_nettype none
module pcrc_fifo_mem
  import pcrc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  wr_en,
  input  wire logic [PCRC_PTR_W-1:0] wr_addr,
  input  wire logic [PCRC_W-1:0]     wr_data,
  input  wire logic [PCRC_PTR_W-1:0] rd_addr,
  output logic      [PCRC_W-1:0]     rd_data_ff
);
  logic [PCRC_W-1:0] mem [PCRC_FIFO_D];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    rd_data_ff <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== rtl/pcrc_generator.sv
// Programmable CRC generator: data FIFO, bit-serial shifter, done interrupt.
// Assumes configuration inputs are steady while a word is being shifted.
`timescale 1ns/1ns
`default_nettype none
module pcrc_generator
  import pcrc_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  nrst,
  input  wire logic [PCRC_W-1:1]     crc_polynomial_register,
  input  wire logic [PCRC_LEN_W-1:0] polynomial_length_field,
  input  wire logic                  crc_clear,
  input  wire logic [PCRC_W-1:0]     in_data,
  input  wire logic                  in_valid,
  output logic                       in_ready_ff,
  output logic                       fifo_empty_ff,
  output logic [PCRC_W-1:0]          crc_result_ff,
  output logic                       busy_ff,
  output logic                       irq_ff
);
  pcrc_state_t           state_ff;
  logic [PCRC_PTR_W-1:0] wr_ptr_ff;
  logic [PCRC_PTR_W-1:0] rd_ptr_ff;
  logic [PCRC_CNT_W-1:0] count_ff;
  logic [PCRC_BIT_W-1:0] bits_ff;
  logic [PCRC_W-1:0]     word_ff;
  logic [PCRC_W-1:0]     rd_data;
  logic                  push;
  logic                  pop;
  logic [PCRC_W-1:0]     nxt_crc;
  logic [PCRC_CNT_W-1:0] nxt_count;

  // Feedback taps: term bits plus the always-present order-zero term
  function automatic logic [PCRC_W-1:0] taps(input logic [PCRC_W-1:1] x);
    taps = {x, 1'b1};
  endfunction

  // Top bit position of a polynomial of order len+1
  function automatic logic [PCRC_LEN_W-1:0] top_bit(input logic [PCRC_LEN_W-1:0] len);
    top_bit = len;
  endfunction

  // One shift of an order-(len+1) LFSR; bits above the order are held at zero
  function automatic logic [PCRC_W-1:0] crc_step(input logic [PCRC_W-1:0] c,
                                                 input logic             din,
                                                 input logic [PCRC_W-1:1] x,
                                                 input logic [PCRC_LEN_W-1:0] len);
    logic              fb;
    logic [PCRC_W-1:0] mask;
    logic [PCRC_W-1:0] t;
    fb   = c[top_bit(len)] ^ din; // order-(len+1) top term always present
    mask = '0;
    for (int i = 0; i < PCRC_W; i++) begin
      if (i <= int'(len)) begin
        mask[i] = 1'b1;
      end
    end
    t = taps(x) & mask;
    crc_step = ({c[PCRC_W-2:0], 1'b0} ^ (fb ? t : '0)) & mask;
  endfunction

  assign push = in_valid && in_ready_ff;
  assign pop  = (state_ff == PCRC_IDLE) && (count_ff != '0);
  assign nxt_count = count_ff + {3'h0, push} - {3'h0, pop};
  assign nxt_crc = crc_step(crc_result_ff, word_ff[PCRC_W-1], crc_polynomial_register,
                            polynomial_length_field);

  // Read data are registered: the word popped in IDLE stands on rd_data in LOAD
  pcrc_fifo_mem u_mem (
    .clock      (clock),
    .wr_en      (push),
    .wr_addr    (wr_ptr_ff),
    .wr_data    (in_data),
    .rd_addr    (rd_ptr_ff),
    .rd_data_ff (rd_data)
  );

  // FIFO pointers and occupancy
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wr_ptr_ff     <= '0;
      rd_ptr_ff     <= '0;
      count_ff      <= '0;
      in_ready_ff   <= 1'b1;
      fifo_empty_ff <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      count_ff      <= nxt_count;
      in_ready_ff   <= nxt_count != PCRC_CNT_FULL;
      fifo_empty_ff <= nxt_count == '0;
    end
  end

  // Word sequencer and shifter
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state_ff      <= PCRC_IDLE;
      bits_ff       <= '0;
      word_ff       <= '0;
      crc_result_ff <= PCRC_RST_VAL;
      busy_ff       <= 1'b0;
    end else begin
      case (state_ff)
        PCRC_IDLE: begin
          if (crc_clear) begin
            crc_result_ff <= PCRC_RST_VAL;
          end
          if (pop) begin
            state_ff <= PCRC_LOAD;
            busy_ff  <= 1'b1;
          end
        end
        PCRC_LOAD: begin
          word_ff  <= rd_data;
          bits_ff  <= PCRC_BITS_WORD;
          state_ff <= PCRC_SHIFT;
        end
        PCRC_SHIFT: begin
          crc_result_ff <= nxt_crc;
          word_ff       <= {word_ff[PCRC_W-2:0], 1'b0};
          bits_ff       <= bits_ff - PCRC_BIT_ONE;
          if (bits_ff == PCRC_BIT_ONE) begin
            state_ff <= PCRC_IDLE;
            busy_ff  <= 1'b0;
          end
        end
        default: begin
          state_ff <= PCRC_IDLE;
          busy_ff  <= 1'b0;
        end
      endcase
    end
  end

  // Interrupt pulse when the last queued word has been folded in
  // A word pushed in the last shift cycle keeps the queue busy, so no pulse then
  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= (state_ff == PCRC_SHIFT) && (bits_ff == PCRC_BIT_ONE) && (count_ff == '0) && !push;
    end
  end

  // Queue properties
  ovf_block_a: assert property (@(posedge clock) disable iff (!nrst)
    (count_ff == PCRC_CNT_FULL) |-> !in_ready_ff)
    else $error("fifo full but ready high");
  full_ready_a: assert property (@(posedge clock) disable iff (!nrst)
    !in_ready_ff |-> (count_ff == PCRC_CNT_FULL))
    else $error("ready low with room left");
  empty_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    fifo_empty_ff == ((wr_ptr_ff == rd_ptr_ff) && in_ready_ff))
    else $error("empty flag mismatch");
  empty_ready_a: assert property (@(posedge clock) disable iff (!nrst)
    fifo_empty_ff |-> in_ready_ff)
    else $error("empty fifo refuses words");
  push_fill_a: assert property (@(posedge clock) disable iff (!nrst)
    (push && !pop) |=> !fifo_empty_ff)
    else $error("accepted word not queued");
  pop_start_a: assert property (@(posedge clock) disable iff (!nrst)
    (!busy_ff && !fifo_empty_ff && state_ff == PCRC_IDLE) |=> busy_ff)
    else $error("queued word not started");
  pop_load_a: assert property (@(posedge clock) disable iff (!nrst)
    pop |=> (state_ff == PCRC_LOAD))
    else $error("popped word not loaded");
  idle_empty_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_IDLE && fifo_empty_ff) |=> !busy_ff)
    else $error("busy with empty queue");
  busy_state_a: assert property (@(posedge clock) disable iff (!nrst)
    busy_ff == (state_ff != PCRC_IDLE))
    else $error("busy flag out of step");
  irq_done_a: assert property (@(posedge clock) disable iff (!nrst)
    irq_ff |-> !busy_ff && fifo_empty_ff)
    else $error("interrupt while work pending");
  irq_once_a: assert property (@(posedge clock) disable iff (!nrst)
    irq_ff |=> !irq_ff)
    else $error("interrupt longer than one cycle");

  // Shifter properties
  word_len_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(busy_ff) |-> ##17 !busy_ff)
    else $error("word did not take sixteen shifts");
  load_count_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_LOAD) |=> (state_ff == PCRC_SHIFT && bits_ff == PCRC_BITS_WORD))
    else $error("load did not arm sixteen shifts");
  bits_range_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT) |-> (bits_ff != '0 && bits_ff <= PCRC_BITS_WORD))
    else $error("shift count out of range");
  const_term_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && (crc_result_ff[polynomial_length_field] ^ word_ff[PCRC_W-1]))
    |=> crc_result_ff[0])
    else $error("order zero term missing");
  no_feed_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && !(crc_result_ff[polynomial_length_field] ^ word_ff[PCRC_W-1]))
    |=> !crc_result_ff[0])
    else $error("feedback without top bit");
  tap_sel_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && polynomial_length_field == '1 && crc_result_ff[15] != word_ff[15])
    |=> crc_result_ff[12] == ($past(crc_result_ff[11]) ^ crc_polynomial_register[12]))
    else $error("tap twelve wrong");
  tap_five_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && polynomial_length_field == '1 && crc_result_ff[15] != word_ff[15])
    |=> crc_result_ff[5] == ($past(crc_result_ff[4]) ^ crc_polynomial_register[5]))
    else $error("tap five wrong");
  top_term_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && polynomial_length_field == '1 && crc_polynomial_register == '0)
    |=> crc_result_ff[0] == ($past(crc_result_ff[15]) ^ $past(word_ff[15])))
    else $error("top term feedback missing");
  order_mask_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT && polynomial_length_field != '1)
    |=> crc_result_ff[15] == 1'b0)
    else $error("bit above order set");
  order_top_a: assert property (@(posedge clock) disable iff (!nrst)
    (state_ff == PCRC_SHIFT) |=> ((crc_result_ff >> polynomial_length_field) <= 16'h0001))
    else $error("bits above order not clear");

  full_c:  cover property (@(posedge clock) disable iff (!nrst) !in_ready_ff);
  irq_c:   cover property (@(posedge clock) disable iff (!nrst) irq_ff);
  b2b_c:   cover property (@(posedge clock) disable iff (!nrst) $fell(busy_ff) ##1 busy_ff);
  short_c: cover property (@(posedge clock) disable iff (!nrst) busy_ff && polynomial_length_field == 4'h7);
  long_c:  cover property (@(posedge clock) disable iff (!nrst) busy_ff && polynomial_length_field == '1);
endmodule
`default_nettype wire

// ===== verification/tb_programmable_crc_generator.sv
// Self-checking bench for the programmable CRC generator.
// Assumes a 50 MHz clock and that config inputs stay steady while a word shifts.
`timescale 1ns/1ns
`default_nettype none
module tb_programmable_crc_generator;
  import pcrc_pkg::*;
  logic              clock, nrst, crc_clear, in_valid, in_ready_ff, fifo_empty_ff, busy_ff, irq_ff;
  logic [PCRC_W-1:1] poly;
  logic [3:0]        plen;
  logic [15:0]       in_data, crc_result_ff, exp_crc;
  int                failures, n_compared, cycles;
  pcrc_generator dut (.clock(clock), .nrst(nrst), .crc_polynomial_register(poly),
    .polynomial_length_field(plen), .crc_clear(crc_clear), .in_data(in_data), .in_valid(in_valid),
    .in_ready_ff(in_ready_ff), .fifo_empty_ff(fifo_empty_ff), .crc_result_ff(crc_result_ff),
    .busy_ff(busy_ff), .irq_ff(irq_ff));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  function automatic logic [15:0] model(logic [15:0] c, logic [15:0] w);
    logic [16:0] m;
    logic        fb;
    m = (17'h00002 << plen) - 17'h00001;
    for (int i = 15; i >= 0; i--) begin
      fb = c[plen] ^ w[i];
      c = ((c << 1) ^ (fb ? {poly, 1'b1} : 16'h0000)) & m[15:0];
    end
    return c;
  endfunction
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic step();
    @(posedge clock);
    #1;
  endtask
  // Leaves in_valid high so back-to-back pushes never toggle it twice in one step
  task automatic push(logic [15:0] w, output logic full_seen);
    in_data = w;
    in_valid = 1'b1;
    full_seen = (in_ready_ff !== 1'b1);
    if (!full_seen) exp_crc = model(exp_crc, w);
    step();
  endtask
  task automatic wait_irq(int limit);
    int k;
    for (k = 0; k < limit && irq_ff !== 1'b1; k++) step();
    check("irq", {15'h0000, irq_ff}, 16'h0001);
    check("crc", crc_result_ff, exp_crc);
    step();
    check("irq_pulse", {15'h0000, irq_ff}, 16'h0000);
  endtask
  task automatic clear_crc();
    crc_clear = 1'b1;
    step();
    crc_clear = 1'b0;
    step();
    exp_crc = 16'h0000;
    check("crc_clr", crc_result_ff, 16'h0000);
  endtask
  task automatic t_reset();
    check("ready", {15'h0000, in_ready_ff}, 16'h0001);
    check("empty", {15'h0000, fifo_empty_ff}, 16'h0001);
    check("busy", {15'h0000, busy_ff}, 16'h0000);
    check("irq_rst", {15'h0000, irq_ff}, 16'h0000);
    check("crc_rst", crc_result_ff, PCRC_RST_VAL);
  endtask
  task automatic t_ccitt();
    logic f;
    plen = 4'hF;
    poly = 15'h0000;
    poly[12] = 1'b1;
    poly[5] = 1'b1;
    clear_crc();
    push(16'h1234, f);
    push(16'hABCD, f);
    in_valid = 1'b0;
    wait_irq(100);
    check("busy_end", {15'h0000, busy_ff}, 16'h0000);
    // Single top bit through x16+x12+x5+1 from zero gives a fixed known value
    clear_crc();
    push(16'h8000, f);
    in_valid = 1'b0;
    wait_irq(60);
    check("crc_known", crc_result_ff, 16'h1B98);
  endtask
  task automatic t_lengths();
    logic [3:0] lens [5] = '{4'h3, 4'h7, 4'hB, 4'hF, 4'hF};
    logic f;
    for (int i = 0; i < 5; i++) begin
      plen = lens[i];
      poly = (i == 4) ? 15'h0000 : 15'h5A5B;
      clear_crc();
      push(16'hC3A5 ^ 16'(i), f);
      in_valid = 1'b0;
      wait_irq(60);
    end
  endtask
  task automatic t_full();
    logic f;
    logic any_full;
    plen = 4'hF;
    poly = 15'h0811;
    any_full = 1'b0;
    clear_crc();
    for (int i = 0; i < 12; i++) begin
      push(16'h1111 * 16'(i + 1), f);
      any_full |= f;
    end
    in_valid = 1'b0;
    check("refused", {15'h0000, any_full}, 16'h0001);
    check("full_ready", {15'h0000, in_ready_ff}, 16'h0000);
    check("full_empty", {15'h0000, fifo_empty_ff}, 16'h0000);
    wait_irq(400);
  endtask
  task automatic t_clear_busy();
    logic f;
    clear_crc();
    push(16'hBEEF, f);
    in_valid = 1'b0;
    check("empty_push", {15'h0000, fifo_empty_ff}, 16'h0000);
    step();
    step();
    check("busy_run", {15'h0000, busy_ff}, 16'h0001);
    crc_clear = 1'b1;
    step();
    crc_clear = 1'b0;
    wait_irq(60);
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    nrst = 1'b0;
    crc_clear = 1'b0;
    in_valid = 1'b0;
    in_data = 16'h0000;
    poly = 15'h0000;
    plen = 4'hF;
    exp_crc = 16'h0000;
    repeat (20) @(posedge clock);
    #1;
    nrst = 1'b1;
    t_reset();
    t_ccitt();
    t_lengths();
    t_full();
    t_clear_busy();
    summarize();
  end
endmodule
`default_nettype wire
